// file: include/spcc_pkg.sv
package spcc_pkg;
    // mode pins {select, enable_n, power_off_n}
    localparam logic [2:0] SPCC_PINS_PRESET = 3'h7;
    localparam logic [2:0] SPCC_PINS_START  = 3'h3;
    localparam logic [2:0] SPCC_PINS_RUN    = 3'h1;
    localparam logic [2:0] SPCC_PINS_COAST  = 3'h0;
    localparam logic [2:0] SPCC_PINS_BRAKE  = 3'h4;
    localparam logic [2:0] SPCC_PINS_CAL    = 3'h6;

    typedef enum logic [2:0] {
        SPCC_MODE_PRESET,
        SPCC_MODE_START,
        SPCC_MODE_RUN,
        SPCC_MODE_COAST,
        SPCC_MODE_BRAKE,
        SPCC_MODE_CAL,
        SPCC_MODE_TEST
    } spcc_mode_e;

    localparam logic [2:0] SPCC_STATE_PRESET = 3'h0;
    localparam logic [2:0] SPCC_STATE_FIRST  = 3'h1;
    localparam logic [2:0] SPCC_STATE_LAST   = 3'h6;

    // drive word order {ul, vl, wl, uh, vh, wh}
    localparam logic [5:0] SPCC_DRV_OFF = 6'h00;
    localparam logic [5:0] SPCC_DRV_S1  = 6'h22;
    localparam logic [5:0] SPCC_DRV_S2  = 6'h21;
    localparam logic [5:0] SPCC_DRV_S3  = 6'h11;
    localparam logic [5:0] SPCC_DRV_S4  = 6'h14;
    localparam logic [5:0] SPCC_DRV_S5  = 6'h0C;
    localparam logic [5:0] SPCC_DRV_S6  = 6'h0A;
    localparam logic [5:0] SPCC_DRV_BRK = 6'h07;
    localparam logic [5:0] SPCC_LOW_MASK = 6'h38;

    localparam int unsigned SPCC_CLK_HZ       = 10_000_000;
    localparam int unsigned SPCC_OFF_TIME_NS  = 20_000;
    localparam int unsigned SPCC_OFF_CYCLES   = (SPCC_OFF_TIME_NS * (SPCC_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SPCC_VCO_DIV      = 12;
    localparam logic [15:0] SPCC_VCO_IDLE_DEF = 16'h0100;
    localparam logic [15:0] SPCC_VCO_MIN_PER  = 16'h0004;
endpackage

// file: src/spcc_ctrl.sv
`timescale 1ns/100ps
// Function
// - start: over-limit fires one-shot disabling low-side drives for fixed off time
// - vco held in reset during open-loop start
// - run: vco output advances commutation, not the advance input
// - run: phase error is undriven minus driven mean, inverted alternate cycles
// - early commutation gives rising positive error raising vco frequency
// - run: status output shows vco or vco divided by six
// - run: over-limit fires one-shot, all low-side gates pulled low
// - coast: all drivers off, tachometer routed to status output
// - brake: all three high-side drivers on together
// - calibration: comparator sees internal reference, its state on status output
// - state 0 all off; states 1..6 enable the tabled driver pairs
// - start: advance on each rising edge of advance input
// - mode decoded from select, enable_n, power_off_n pins per table
// - status output selected per mode as tabulated
module spcc_ctrl #(
    parameter int unsigned OFF_CYCLES = spcc_pkg::SPCC_OFF_CYCLES,
    parameter int unsigned VCO_DIV    = spcc_pkg::SPCC_VCO_DIV
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        sense_input_select_i,
    input  wire logic        mode_enable_n_i,
    input  wire logic        spindle_power_off_n_i,
    input  wire logic        advance_i,
    input  wire logic        pwm_drive_i,
    input  wire logic        sense_over_limit_i,
    input  wire logic        cal_over_limit_i,
    input  wire logic        tach_i,
    input  wire logic        phase_early_i,
    input  wire logic        phase_late_i,
    output logic             u_low_drive_o,
    output logic             v_low_drive_o,
    output logic             w_low_drive_o,
    output logic             u_high_drive_o,
    output logic             v_high_drive_o,
    output logic             w_high_drive_o,
    output logic             status_mux_out_o,
    output logic             vco_out_o,
    output logic             phase_invert_o,
    output logic             cal_reference_sel_o,
    output logic [2:0]       comm_state_o
);
    import spcc_pkg::*;

    logic sel_s, en_n_s, pwr_n_s, adv_s, pwm_s, sns_s, cal_s, tach_s, early_s, late_s;

    spcc_sync u_sy0 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(sense_input_select_i),  .q_o(sel_s));
    spcc_sync u_sy1 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(mode_enable_n_i),       .q_o(en_n_s));
    spcc_sync u_sy2 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(spindle_power_off_n_i), .q_o(pwr_n_s));
    spcc_sync u_sy3 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(advance_i),             .q_o(adv_s));
    spcc_sync u_sy4 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(pwm_drive_i),           .q_o(pwm_s));
    spcc_sync u_sy5 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(sense_over_limit_i),    .q_o(sns_s));
    spcc_sync u_sy6 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(cal_over_limit_i),      .q_o(cal_s));
    spcc_sync u_sy7 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(tach_i),                .q_o(tach_s));
    spcc_sync u_sy8 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(phase_early_i),         .q_o(early_s));
    spcc_sync u_sy9 (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(phase_late_i),          .q_o(late_s));

    spcc_mode_e mode;
    logic       adv_d;
    logic       adv_rise;
    logic       vco_tick;
    logic       step;
    logic       comparator;

    always_comb begin
        case ({sel_s, en_n_s, pwr_n_s})
            SPCC_PINS_PRESET: mode = SPCC_MODE_PRESET;
            SPCC_PINS_START:  mode = SPCC_MODE_START;
            SPCC_PINS_RUN:    mode = SPCC_MODE_RUN;
            SPCC_PINS_COAST:  mode = SPCC_MODE_COAST;
            SPCC_PINS_BRAKE:  mode = SPCC_MODE_BRAKE;
            SPCC_PINS_CAL:    mode = SPCC_MODE_CAL;
            default:          mode = SPCC_MODE_TEST;
        endcase
    end

    wire logic vco_held = (mode == SPCC_MODE_START);
    wire logic sm_reset = (mode == SPCC_MODE_PRESET) || (mode == SPCC_MODE_BRAKE)
                          || (mode == SPCC_MODE_CAL);
    wire logic vco_runs = (mode == SPCC_MODE_RUN) || (mode == SPCC_MODE_COAST);

    // calibration swaps the comparator onto the internal reference
    assign comparator = (mode == SPCC_MODE_CAL) ? cal_s : sns_s;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            adv_d <= 1'b0;
        end else begin
            adv_d <= adv_s;
        end
    end
    assign adv_rise = adv_s && !adv_d;

    // vco model: period counter trimmed by phase error
    logic [15:0] vco_period;
    logic [15:0] vco_cnt;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vco_period <= SPCC_VCO_IDLE_DEF;
        end else if (!vco_runs) begin
            vco_period <= SPCC_VCO_IDLE_DEF;
        end else if (vco_tick && early_s && !late_s && vco_period > SPCC_VCO_MIN_PER) begin
            vco_period <= vco_period - 16'h0001;
        end else if (vco_tick && late_s && !early_s && vco_period != 16'hFFFF) begin
            vco_period <= vco_period + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vco_cnt <= 16'h0000;
        end else if (vco_held) begin
            vco_cnt <= 16'h0000;
        end else if (vco_cnt + 16'h0001 >= vco_period) begin
            vco_cnt <= 16'h0000;
        end else begin
            vco_cnt <= vco_cnt + 16'h0001;
        end
    end
    // idle vco still runs in preset so its frequency can be measured
    assign vco_tick = !vco_held && (vco_cnt + 16'h0001 >= vco_period);

    always_comb begin
        case (mode)
            SPCC_MODE_START: step = adv_rise;
            SPCC_MODE_RUN:   step = vco_tick;
            SPCC_MODE_COAST: step = vco_tick;
            default:         step = 1'b0;
        endcase
    end

    logic [2:0] state;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= SPCC_STATE_PRESET;
        end else if (sm_reset) begin
            state <= SPCC_STATE_PRESET;
        end else if (step) begin
            if (state == SPCC_STATE_LAST || state == SPCC_STATE_PRESET) begin
                state <= SPCC_STATE_FIRST;
            end else begin
                state <= state + 3'h1;
            end
        end
    end

    // inversion flips every run-mode commutation step for positive error pulses; held clear in start and coast
    logic inv;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            inv <= 1'b0;
        end else if (mode != SPCC_MODE_RUN) begin
            inv <= 1'b0;
        end else if (step) begin
            inv <= ~inv;
        end
    end

    // one-shot: retriggerless fixed off time
    localparam int unsigned OS_W = $clog2(OFF_CYCLES + 1);
    logic [OS_W-1:0] os_cnt;
    wire logic os_active = (os_cnt != '0);
    wire logic os_fire = comparator && !os_active
                         && ((mode == SPCC_MODE_START) || (mode == SPCC_MODE_RUN));

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            os_cnt <= '0;
        end else if (os_fire) begin
            os_cnt <= OS_W'(OFF_CYCLES);
        end else if (os_active) begin
            os_cnt <= os_cnt - OS_W'(1);
        end
    end

    // vco output divided by six: div_sq toggles every six vco ticks, a twelve-tick period
    localparam int unsigned DV_W = $clog2(VCO_DIV);
    logic [DV_W-1:0] div_cnt;
    logic            vco_sq;
    logic            div_sq;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vco_sq  <= 1'b0;
            div_cnt <= '0;
            div_sq  <= 1'b0;
        end else if (vco_held) begin
            vco_sq  <= 1'b0;
            div_cnt <= '0;
            div_sq  <= 1'b0;
        end else if (vco_tick) begin
            vco_sq <= ~vco_sq;
            if (div_cnt == DV_W'(VCO_DIV / 2 - 1)) begin
                div_cnt <= '0;
                div_sq  <= ~div_sq;
            end else begin
                div_cnt <= div_cnt + DV_W'(1);
            end
        end
    end

    logic [5:0] table_word;
    always_comb begin
        case (state)
            3'h1:    table_word = SPCC_DRV_S1;
            3'h2:    table_word = SPCC_DRV_S2;
            3'h3:    table_word = SPCC_DRV_S3;
            3'h4:    table_word = SPCC_DRV_S4;
            3'h5:    table_word = SPCC_DRV_S5;
            3'h6:    table_word = SPCC_DRV_S6;
            default: table_word = SPCC_DRV_OFF;
        endcase
    end

    logic [5:0] next_drive;
    always_comb begin
        case (mode)
            SPCC_MODE_START, SPCC_MODE_RUN: begin
                next_drive = table_word;
                if (os_fire || os_active || !pwm_s) begin
                    next_drive = table_word & ~SPCC_LOW_MASK;
                end
            end
            SPCC_MODE_BRAKE: next_drive = SPCC_DRV_BRK;
            default:         next_drive = SPCC_DRV_OFF;
        endcase
    end

    logic next_status;
    always_comb begin
        case (mode)
            SPCC_MODE_PRESET: next_status = vco_sq;
            SPCC_MODE_RUN:    next_status = adv_s ? vco_sq : div_sq;
            SPCC_MODE_START:  next_status = comparator;
            SPCC_MODE_CAL:    next_status = comparator;
            SPCC_MODE_COAST:  next_status = tach_s;
            default:          next_status = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {u_low_drive_o, v_low_drive_o, w_low_drive_o} <= 3'h0;
            {u_high_drive_o, v_high_drive_o, w_high_drive_o} <= 3'h0;
            status_mux_out_o    <= 1'b0;
            vco_out_o           <= 1'b0;
            phase_invert_o      <= 1'b0;
            cal_reference_sel_o <= 1'b0;
            comm_state_o        <= SPCC_STATE_PRESET;
        end else begin
            {u_low_drive_o, v_low_drive_o, w_low_drive_o,
             u_high_drive_o, v_high_drive_o, w_high_drive_o} <= next_drive;
            status_mux_out_o    <= next_status;
            vco_out_o           <= vco_sq;
            phase_invert_o      <= inv;
            cal_reference_sel_o <= (mode == SPCC_MODE_CAL);
            comm_state_o        <= state;
        end
    end

    // brake mode drives exactly the three high sides, one cycle after decode
    property p_brake_high;
        @(posedge clk_i) disable iff (!nrst_i)
        (mode == SPCC_MODE_BRAKE) |=> (u_high_drive_o && v_high_drive_o && w_high_drive_o
                                       && !u_low_drive_o && !v_low_drive_o && !w_low_drive_o);
    endproperty
    a_brake_high: assert property (p_brake_high) else $error("brake drive wrong");

    property p_coast_off;
        @(posedge clk_i) disable iff (!nrst_i)
        (mode == SPCC_MODE_COAST) |=> ({u_low_drive_o, v_low_drive_o, w_low_drive_o,
                                        u_high_drive_o, v_high_drive_o, w_high_drive_o} == 6'h00)
                                      && (status_mux_out_o == $past(tach_s));
    endproperty
    a_coast_off: assert property (p_coast_off) else $error("coast output wrong");

    property p_oneshot_low;
        @(posedge clk_i) disable iff (!nrst_i)
        os_fire |=> !u_low_drive_o && !v_low_drive_o && !w_low_drive_o && os_active;
    endproperty
    a_oneshot_low: assert property (p_oneshot_low) else $error("low side not cut");

    property p_oneshot_len;
        @(posedge clk_i) disable iff (!nrst_i)
        os_fire |=> (os_cnt == OS_W'(OFF_CYCLES));
    endproperty
    a_oneshot_len: assert property (p_oneshot_len) else $error("off time wrong");

    property p_reset_state;
        @(posedge clk_i) disable iff (!nrst_i)
        sm_reset |=> (state == SPCC_STATE_PRESET);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state not cleared");

    property p_wrap;
        @(posedge clk_i) disable iff (!nrst_i)
        (step && !sm_reset && state == SPCC_STATE_LAST) |=> (state == SPCC_STATE_FIRST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to state one");

    property p_start_no_vco;
        @(posedge clk_i) disable iff (!nrst_i)
        (mode == SPCC_MODE_START) |-> (!vco_tick && (step == adv_rise)) ##1 !vco_sq;
    endproperty
    a_start_no_vco: assert property (p_start_no_vco) else $error("vco runs in start");

    property p_run_step;
        @(posedge clk_i) disable iff (!nrst_i)
        (mode == SPCC_MODE_RUN) |-> (step == vco_tick);
    endproperty
    a_run_step: assert property (p_run_step) else $error("run step source wrong");

    property p_state2;
        @(posedge clk_i) disable iff (!nrst_i)
        (state == 3'h2 && mode == SPCC_MODE_RUN && pwm_s && !os_active && !os_fire)
            |=> u_low_drive_o && w_high_drive_o && !v_high_drive_o;
    endproperty
    a_state2: assert property (p_state2) else $error("state two drive wrong");

    property p_invert;
        @(posedge clk_i) disable iff (!nrst_i)
        (mode == SPCC_MODE_RUN && step) |=> (inv != $past(inv));
    endproperty
    a_invert: assert property (p_invert) else $error("invert not toggled");
endmodule // spcc_ctrl

// file: src/spcc_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for one pin level
module spcc_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // spcc_sync

// file: tb/spcc_host_model.sv
`timescale 1ns/100ps
// controller side: mode pins, step pulses and pwm, all moved just after an edge
module spcc_host_model (
    input  wire logic clk_i,
    output logic      sense_input_select_o,
    output logic      mode_enable_n_o,
    output logic      spindle_power_off_n_o,
    output logic      advance_o,
    output logic      pwm_drive_o,
    output logic      cal_over_limit_o
);
    import spcc_pkg::*;

    initial begin
        {sense_input_select_o, mode_enable_n_o, spindle_power_off_n_o} = SPCC_PINS_PRESET;
        advance_o   = 1'b0;
        pwm_drive_o = 1'b1;
        cal_over_limit_o = 1'b0;
    end

    // limit ramp as seen through the calibration comparator
    task automatic set_cal_cmp(input logic lvl);
        @(posedge clk_i);
        #10;
        cal_over_limit_o = lvl;
    endtask

    // waits out the two sync flops plus the output register
    task automatic set_mode(input logic [2:0] pins);
        @(posedge clk_i);
        #10;
        {sense_input_select_o, mode_enable_n_o, spindle_power_off_n_o} = pins;
        repeat (5) @(posedge clk_i);
        #10;
    endtask

    // open loop step; levels held beyond the two-clock minimum for margin
    task automatic step();
        @(posedge clk_i);
        #10;
        advance_o = 1'b1;
        repeat (3) @(posedge clk_i);
        #10;
        advance_o = 1'b0;
        repeat (4) @(posedge clk_i);
        #10;
    endtask

    task automatic set_adv(input logic lvl);
        @(posedge clk_i);
        #10;
        advance_o = lvl;
    endtask

    task automatic set_pwm(input logic lvl);
        @(posedge clk_i);
        #10;
        pwm_drive_o = lvl;
    endtask
endmodule // spcc_host_model

// file: tb/tb_spindle_commutation_control.sv
`timescale 1ns/100ps
module tb_spindle_commutation_control;
    import spcc_pkg::*;
    localparam int unsigned OFF_CYC = 20;
    localparam int unsigned MAX_CYC = 30000;

    logic       clk_i, nrst_i, sel, en_n, pwr_n, adv, pwm;
    logic       sense_over, cal_over, tach, early, late;
    logic       ul, vl, wl, uh, vh, wh, status, vco, pinv, calsel;
    logic [2:0] state;
    logic [5:0] drv;
    logic [5:0] tbl [0:6];
    int         errors, n_compared, cyc, p0, p1, p2, n;

    assign drv = {ul, vl, wl, uh, vh, wh};

    spcc_host_model i_host (.clk_i(clk_i), .sense_input_select_o(sel), .mode_enable_n_o(en_n),
        .spindle_power_off_n_o(pwr_n), .advance_o(adv), .pwm_drive_o(pwm), .cal_over_limit_o(cal_over));

    spcc_ctrl #(.OFF_CYCLES(OFF_CYC)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .sense_input_select_i(sel), .mode_enable_n_i(en_n), .spindle_power_off_n_i(pwr_n),
        .advance_i(adv), .pwm_drive_i(pwm), .sense_over_limit_i(sense_over),
        .cal_over_limit_i(cal_over), .tach_i(tach), .phase_early_i(early), .phase_late_i(late),
        .u_low_drive_o(ul), .v_low_drive_o(vl), .w_low_drive_o(wl), .u_high_drive_o(uh),
        .v_high_drive_o(vh), .w_high_drive_o(wh), .status_mux_out_o(status), .vco_out_o(vco),
        .phase_invert_o(pinv), .cal_reference_sel_o(calsel), .comm_state_o(state));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic close_out();
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            errors++;
            close_out();
        end
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0, got}, {15'h0, exp});
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) begin
            @(posedge clk_i);
            #10;
        end
    endtask

    task automatic wait_vco(output int k);
        logic v;
        v = vco;
        k = 0;
        while (vco === v && k < 2000) begin
            wait_cyc(1);
            k++;
        end
    endtask

    task automatic vco_follow();
        int k;
        wait_vco(k);
        wait_cyc(3);
        chk_bit(status, vco);
    endtask

    // both source levels are driven, so a stuck status output shows
    task automatic mux_follow(input int which);
        for (int lv = 1; lv >= 0; lv--) begin
            case (which)
                0: sense_over = lv[0];
                1: tach = lv[0];
                default: i_host.set_cal_cmp(lv[0]);
            endcase
            wait_cyc(5);
            chk_bit(status, lv[0]);
        end
    endtask

    task automatic oneshot();
        sense_over = 1'b1;
        wait_cyc(1);
        sense_over = 1'b0;
        wait_cyc(4);
        chk_word({10'h0, drv & SPCC_LOW_MASK}, 16'h0000);
        wait_cyc(OFF_CYC - 8);
        chk_word({10'h0, drv & SPCC_LOW_MASK}, 16'h0000);
        wait_cyc(12);
        chk_bit(|(drv & SPCC_LOW_MASK), 1'b1);
    endtask

    task automatic run_step();
        logic [2:0] st;
        logic       pi;
        int         k;
        st = state;
        pi = pinv;
        k = 0;
        while (state === st && k < 1000) begin
            wait_cyc(1);
            k++;
        end
        wait_cyc(2);
        chk_word({13'h0, state}, {13'h0, (st == SPCC_STATE_LAST) ? SPCC_STATE_FIRST : st + 3'h1});
        chk_bit(pinv, ~pi);
    endtask

    // vco toggles counted across one half period of the divided output
    task automatic div_check();
        int   k, t;
        logic s, v;
        t = 0;
        wait_cyc(5);
        s = status;
        k = 0;
        while (status === s && k < 4000) begin
            wait_cyc(1);
            k++;
        end
        s = status;
        k = 0;
        while (status === s && k < 4000) begin
            v = vco;
            wait_cyc(1);
            if (vco !== v) t++;
            k++;
        end
        chk_word(16'(t), 16'(SPCC_VCO_DIV / 2));
    endtask

    initial begin
        tbl = '{SPCC_DRV_OFF, SPCC_DRV_S1, SPCC_DRV_S2, SPCC_DRV_S3, SPCC_DRV_S4, SPCC_DRV_S5, SPCC_DRV_S6};
        errors = 0;
        n_compared = 0;
        cyc = 0;
        nrst_i = 1'b0;
        {sense_over, tach, early, late} = 4'h0;
        repeat (3) @(posedge clk_i);
        #10;
        nrst_i = 1'b1;
        wait_cyc(4);
        chk_word({10'h0, drv}, {10'h0, SPCC_DRV_OFF});
        chk_word({13'h0, state}, {13'h0, SPCC_STATE_PRESET});
        vco_follow();
        i_host.set_mode(SPCC_PINS_START);
        for (int k = 1; k <= 7; k++) begin
            i_host.step();
            chk_word({13'h0, state}, 16'((k - 1) % 6 + 1));
            chk_word({10'h0, drv}, {10'h0, tbl[(k - 1) % 6 + 1]});
            chk_bit(vco, 1'b0);
        end
        oneshot();
        mux_follow(0);
        wait_cyc(OFF_CYC + 5);
        i_host.set_adv(1'b1);
        i_host.set_mode(SPCC_PINS_RUN);
        run_step();
        run_step();
        vco_follow();
        i_host.set_adv(1'b0);
        div_check();
        i_host.set_adv(1'b1);
        wait_vco(n);
        wait_vco(p0);
        early = 1'b1;
        wait_cyc(2000);
        wait_vco(n);
        wait_vco(p1);
        chk_bit(p1 < p0, 1'b1);
        early = 1'b0;
        late = 1'b1;
        wait_cyc(2000);
        wait_vco(n);
        wait_vco(p2);
        chk_bit(p2 > p1, 1'b1);
        late = 1'b0;
        oneshot();
        wait_cyc(OFF_CYC + 5);
        i_host.set_pwm(1'b0);
        wait_cyc(5);
        chk_word({10'h0, drv & SPCC_LOW_MASK}, 16'h0000);
        i_host.set_pwm(1'b1);
        i_host.set_mode(SPCC_PINS_COAST);
        chk_word({10'h0, drv}, {10'h0, SPCC_DRV_OFF});
        mux_follow(1);
        i_host.set_mode(SPCC_PINS_BRAKE);
        chk_word({10'h0, drv}, {10'h0, SPCC_DRV_BRK});
        chk_word({13'h0, state}, {13'h0, SPCC_STATE_PRESET});
        chk_bit(status, 1'b0);
        i_host.set_mode(SPCC_PINS_CAL);
        chk_word({10'h0, drv}, {10'h0, SPCC_DRV_OFF});
        chk_bit(calsel, 1'b1);
        mux_follow(2);
        i_host.set_mode(3'h2);
        chk_word({10'h0, drv}, {10'h0, SPCC_DRV_OFF});
        chk_bit(status, 1'b0);
        close_out();
    end
endmodule // tb_spindle_commutation_control
